// File: rtl/adc_ctrl_pkg.sv
// Shared constants and types of the converter control and result block
package adc_ctrl_pkg;

  // Register byte addresses on the APB side
  localparam logic [7:0] ADDR_INPUT_REF   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B      = 8'h04;
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h08;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h14;
  localparam logic [7:0] ADDR_CONV_STATE  = 8'h18;

  // Field positions of input_reference_select_reg
  localparam int REF_BIT1_POS    = 7;
  localparam int REF_BIT0_POS    = 6;
  localparam int LEFT_ADJUST_POS = 5;
  localparam int REF_BIT2_POS    = 4;
  localparam int CHAN_MSB        = 3;

  // Field positions of converter_control_reg_b
  localparam int BIPOLAR_POS  = 7;
  localparam int POL_REV_POS  = 5;
  localparam logic [7:0] CTRL_B_WMASK = 8'hA0;

  // Interrupt event bit positions
  localparam int EV_DONE_POS    = 0;
  localparam int EV_DROPPED_POS = 1;

  // Reset values
  localparam logic [7:0] INPUT_REF_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET    = 8'h00;
  localparam logic [1:0] IRQ_MASK_RESET  = 2'h0;

  // Conversion lengths in converter clock cycles
  localparam logic [4:0] NORMAL_CONV_CLKS = 5'd13;
  localparam logic [4:0] LONG_CONV_CLKS   = 5'd25;

  // Result limits
  localparam logic [9:0] UNI_MAX = 10'h3FF;
  localparam logic [9:0] UNI_MIN = 10'h000;
  localparam logic [9:0] BIP_MAX = 10'h1FF;
  localparam logic [9:0] BIP_MIN = 10'h200;

  // Channel codes
  localparam logic [3:0] CH_DIFF_FIRST = 4'h4;
  localparam logic [3:0] CH_DIFF_LAST  = 4'hB;
  localparam logic [3:0] CH_BANDGAP    = 4'hC;
  localparam logic [3:0] CH_GROUND     = 4'hD;
  localparam logic [3:0] CH_UNUSED     = 4'hE;
  localparam logic [3:0] CH_TEMP       = 4'hF;

  typedef enum logic [2:0] {
    IN_ZERO    = 3'b000,
    IN_ONE     = 3'b001,
    IN_TWO     = 3'b010,
    IN_THREE   = 3'b011,
    IN_TEMP    = 3'b100,
    IN_BANDGAP = 3'b101,
    IN_GROUND  = 3'b110,
    IN_NONE    = 3'b111
  } analog_in_t;

  typedef enum logic [2:0] {
    REF_SUPPLY     = 3'b000,
    REF_EXT_PIN    = 3'b001,
    REF_INT_1V1    = 3'b010,
    REF_RESERVED   = 3'b011,
    REF_INT_2V56   = 3'b100,
    REF_INT_2V56_C = 3'b101
  } ref_src_t;

  typedef enum logic [0:0] {
    CONV_IDLE = 1'b0,
    CONV_BUSY = 1'b1
  } conv_state_t;

  typedef struct packed {
    analog_in_t pos_in;
    analog_in_t neg_in;
    logic       differential;
    logic       gain_20x;
    logic       temp_sensor_en;
  } chan_sel_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// File: rtl/adc_mux_ref_result_format.sv
// Converter input select, reference select and result formatting
//
// Functional notes
// - Unipolar differential results run 0x000 to 0x3FF, clamping at 0.
// - Unipolar by default; the control reg B bipolar bit allows negatives on differential codes.
// - Bipolar results are 10-bit two's complement from 0x200 through 0x1FF.
// - In bipolar mode result bit 9 is the sign, one meaning negative.
// - Differential codes drive the gain stage at 1x or 20x per the code.
// - Code 1111 routes the temperature sensor as channel four and enables it.
// - A reference change during a conversion waits for its completion.
// - After a reference change the next conversion is asked to run 25 clocks.
// - Ref codes map to supply, pin, 1.1V, reserved, 2.56V, 2.56V+cap.
// - The left-adjust bit re-presents the data register at once.
// - A channel change during a conversion waits for its completion.
// - Codes 0-3 pick single inputs, 1100 bandgap, 1101 ground, 1110 unused.
// - Codes 0100-1011 pick the differential pairs at 1x or 20x.
// - Left adjust puts 9..2 high, 1..0 atop low; right puts 7..0 low, 9..8 at the foot of high.
// - A low byte read holds the data register until the high byte read.
`timescale 1ns/10ps
module adc_mux_ref_result_format (
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    ce_in,
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [7:0]              paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output logic      [31:0]             prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  input  wire logic                    conv_start_in,
  input  wire logic                    conv_done_in,
  input  wire logic [10:0]             conv_raw_in,
  output adc_ctrl_pkg::chan_sel_t      chan_sel_out,
  output adc_ctrl_pkg::ref_src_t       ref_src_out,
  output logic      [4:0]              conv_len_out,
  output logic                         irq_out
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    conv_state_t fsm;
    logic [7:0]  input_ref;
    logic [7:0]  ctrl_b;
    logic [9:0]  result;
    logic        locked;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [3:0]  act_chan;
    logic [2:0]  act_ref;
    logic        long_pending;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    chan_sel_t   chan;
    ref_src_t    ref_src;
    logic [4:0]  conv_len;
  } state_t;

  state_t   state_reg;
  state_t   state_next;
  apb_req_t req;

  // Channel code to analog routing
  function automatic chan_sel_t decode_chan(input logic [3:0] code);
    chan_sel_t c;
    c = '{pos_in: IN_NONE, neg_in: IN_NONE, differential: 1'b0,
          gain_20x: 1'b0, temp_sensor_en: 1'b0};
    case (code)
      4'h0: c.pos_in = IN_ZERO;
      4'h1: c.pos_in = IN_ONE;
      4'h2: c.pos_in = IN_TWO;
      4'h3: c.pos_in = IN_THREE;
      4'h4, 4'h5: begin
        c.pos_in = IN_TWO;
        c.neg_in = IN_TWO;
      end
      4'h6, 4'h7: begin
        c.pos_in = IN_TWO;
        c.neg_in = IN_THREE;
      end
      4'h8, 4'h9: begin
        c.pos_in = IN_ZERO;
        c.neg_in = IN_ZERO;
      end
      4'hA, 4'hB: begin
        c.pos_in = IN_ZERO;
        c.neg_in = IN_ONE;
      end
      CH_BANDGAP: c.pos_in = IN_BANDGAP;
      CH_GROUND:  c.pos_in = IN_GROUND;
      CH_TEMP: begin
        c.pos_in         = IN_TEMP;
        c.temp_sensor_en = 1'b1;
      end
      default: c.pos_in = IN_NONE;
    endcase
    if (code >= CH_DIFF_FIRST && code <= CH_DIFF_LAST) begin
      c.differential = 1'b1;
      c.gain_20x     = code[0];
    end
    return c;
  endfunction

  // Reference bits to source; the top bit only matters for internal codes
  function automatic ref_src_t decode_ref(input logic [2:0] code);
    ref_src_t r;
    case (code)
      3'b000, 3'b100: r = REF_SUPPLY;
      3'b001, 3'b101: r = REF_EXT_PIN;
      3'b010:         r = REF_INT_1V1;
      3'b110:         r = REF_INT_2V56;
      3'b111:         r = REF_INT_2V56_C;
      default:        r = REF_RESERVED;
    endcase
    return r;
  endfunction

  // Raw signed difference, full scale 1024, to the 10-bit result code
  function automatic logic [9:0] format_result(
    input logic [10:0] raw,
    input logic        diff,
    input logic        bipolar,
    input logic        pol_rev
  );
    logic signed [11:0] v;
    logic signed [11:0] half;
    logic [9:0]         r;
    v    = {raw[10], raw};
    half = v >>> 1;
    r    = UNI_MIN;
    if (diff && bipolar) begin
      // Half the scale buys room for the sign bit
      if (half > 12'sd511)
        r = BIP_MAX;
      else if (half < -12'sd512)
        r = BIP_MIN;
      else
        r = half[9:0];
    end else begin
      if (diff && pol_rev)
        v = -v;
      if (v[11])
        r = UNI_MIN;
      else if (v > 12'sd1023)
        r = UNI_MAX;
      else
        r = v[9:0];
    end
    return r;
  endfunction

  // Byte view of the result under the current adjustment
  function automatic logic [7:0] result_byte(
    input logic [9:0] res,
    input logic       left,
    input logic       high
  );
    logic [7:0] b;
    if (left)
      b = high ? res[9:2] : {res[1:0], 6'h00};
    else
      b = high ? {6'h00, res[9:8]} : res[7:0];
    return b;
  endfunction

  assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                 paddr: paddr_in, pwdata: pwdata_in};

  // Next state: APB slave, conversion tracking, result capture, interrupt
  always_comb begin
    logic       setup;
    logic       access;
    logic       wr;
    logic       rd;
    logic       mapped;
    logic [1:0] ev;
    logic [1:0] clr;
    logic [2:0] new_ref;
    logic [2:0] cur_ref;
    logic       left;
    chan_sel_t  ac;
    state_next = state_reg;
    setup   = req.psel && !req.penable;
    access  = req.psel && req.penable && state_reg.pready;
    wr      = access && req.pwrite;
    rd      = access && !req.pwrite;
    mapped  = 1'b0;
    ev      = 2'h0;
    clr     = 2'h0;
    new_ref = {req.pwdata[REF_BIT2_POS], req.pwdata[REF_BIT1_POS],
               req.pwdata[REF_BIT0_POS]};
    cur_ref = {state_reg.input_ref[REF_BIT2_POS],
               state_reg.input_ref[REF_BIT1_POS],
               state_reg.input_ref[REF_BIT0_POS]};
    left    = state_reg.input_ref[LEFT_ADJUST_POS];
    ac      = decode_chan(state_reg.act_chan);

    // Setup phase builds the answer; access phase always completes
    state_next.pready  = setup;
    state_next.pslverr = 1'b0;
    if (setup) begin
      state_next.prdata = 32'h0000_0000;
      mapped = 1'b1;
      case (req.paddr)
        ADDR_INPUT_REF:   state_next.prdata[7:0] = state_reg.input_ref;
        ADDR_CTRL_B:      state_next.prdata[7:0] = state_reg.ctrl_b;
        // Built from the live adjust bit so a flip shows at once
        ADDR_RESULT_LOW:  state_next.prdata[7:0] =
                            result_byte(state_reg.result, left, 1'b0);
        ADDR_RESULT_HIGH: state_next.prdata[7:0] =
                            result_byte(state_reg.result, left, 1'b1);
        ADDR_IRQ_STATUS:  state_next.prdata[1:0] = state_reg.status;
        ADDR_IRQ_MASK:    state_next.prdata[1:0] = state_reg.mask;
        ADDR_CONV_STATE:  state_next.prdata[1:0] =
                            {state_reg.locked, state_reg.fsm == CONV_BUSY};
        default:          mapped = 1'b0;
      endcase
      state_next.pslverr = !mapped;
    end else if (access) begin
      state_next.pslverr = state_reg.pslverr;
    end

    // Register writes
    if (wr) begin
      case (req.paddr)
        ADDR_INPUT_REF: begin
          state_next.input_ref = req.pwdata[7:0];
          if (new_ref != cur_ref)
            state_next.long_pending = 1'b1;
        end
        ADDR_CTRL_B:
          state_next.ctrl_b = req.pwdata[7:0] & CTRL_B_WMASK;
        ADDR_IRQ_STATUS: clr = req.pwdata[1:0];
        ADDR_IRQ_MASK:   state_next.mask = req.pwdata[1:0];
        default: ;
      endcase
    end

    // Low byte read freezes the data register, high byte read frees it
    if (rd && req.paddr == ADDR_RESULT_LOW)
      state_next.locked = 1'b1;
    if (rd && req.paddr == ADDR_RESULT_HIGH)
      state_next.locked = 1'b0;

    // Conversion tracking; settings only move while no conversion runs
    case (state_reg.fsm)
      CONV_IDLE: begin
        state_next.act_chan = state_reg.input_ref[CHAN_MSB:0];
        state_next.act_ref  = cur_ref;
        if (conv_start_in) begin
          state_next.fsm = CONV_BUSY;
          if (!(wr && req.paddr == ADDR_INPUT_REF))
            state_next.long_pending = 1'b0;
        end
      end
      CONV_BUSY: begin
        if (conv_done_in) begin
          state_next.fsm      = CONV_IDLE;
          state_next.act_chan = state_reg.input_ref[CHAN_MSB:0];
          state_next.act_ref  = cur_ref;
          ev[EV_DONE_POS] = 1'b1;
          // A frozen register drops the new result rather than tear it
          if (state_reg.locked && !(rd && req.paddr == ADDR_RESULT_HIGH))
            ev[EV_DROPPED_POS] = 1'b1;
          else
            state_next.result = format_result(conv_raw_in,
                                  ac.differential,
                                  state_reg.ctrl_b[BIPOLAR_POS],
                                  state_reg.ctrl_b[POL_REV_POS]);
        end
      end
      default: state_next.fsm = CONV_IDLE;
    endcase

    // Sticky events, set wins over a write-one clear
    state_next.status = (state_reg.status & ~clr) | ev;
    state_next.irq    = |(state_next.status & state_next.mask);

    // Registered views for the analog side
    state_next.chan     = decode_chan(state_next.act_chan);
    state_next.ref_src  = decode_ref(state_next.act_ref);
    state_next.conv_len = state_next.long_pending ? LONG_CONV_CLKS
                                                  : NORMAL_CONV_CLKS;
  end

  // State register; clock enable low freezes everything
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= '{fsm: CONV_IDLE, input_ref: INPUT_REF_RESET,
                     ctrl_b: CTRL_B_RESET, result: 10'h000, locked: 1'b0,
                     status: 2'h0, mask: IRQ_MASK_RESET, act_chan: 4'h0,
                     act_ref: 3'h0, long_pending: 1'b0,
                     prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
                     irq: 1'b0,
                     chan: '{pos_in: IN_ZERO, neg_in: IN_NONE,
                             differential: 1'b0, gain_20x: 1'b0,
                             temp_sensor_en: 1'b0},
                     ref_src: REF_SUPPLY, conv_len: NORMAL_CONV_CLKS};
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign prdata_out   = state_reg.prdata;
  assign pready_out   = state_reg.pready;
  assign pslverr_out  = state_reg.pslverr;
  assign chan_sel_out = state_reg.chan;
  assign ref_src_out  = state_reg.ref_src;
  assign conv_len_out = state_reg.conv_len;
  assign irq_out      = state_reg.irq;

endmodule

// File: testbench/adc_mux_ref_result_format_chk.sv
// Port checker of the converter control block
`timescale 1ns/10ps
module adc_mux_ref_result_format_chk
  import adc_ctrl_pkg::*;
(
  input wire logic                    ref_clk_in,
  input wire logic                    rst_in,
  input wire logic                    ce_in,
  input wire logic                    psel_in,
  input wire logic                    penable_in,
  input wire logic                    pwrite_in,
  input wire logic [7:0]              paddr_in,
  input wire logic [31:0]             pwdata_in,
  input wire logic [31:0]             prdata_out,
  input wire logic                    pready_out,
  input wire logic                    pslverr_out,
  input wire logic                    conv_start_in,
  input wire logic                    conv_done_in,
  input wire logic [10:0]             conv_raw_in,
  input wire adc_ctrl_pkg::chan_sel_t chan_sel_out,
  input wire adc_ctrl_pkg::ref_src_t  ref_src_out,
  input wire logic [4:0]              conv_len_out,
  input wire logic                    irq_out
);
  logic busy_q;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // Own view of a conversion in flight, from the core's pulses
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in)
      busy_q <= 1'h0;
    else if (conv_start_in && !busy_q)
      busy_q <= 1'h1;
    else if (conv_done_in && busy_q)
      busy_q <= 1'h0;
  end

  sequence apb_setup;
    psel_in && !penable_in && ce_in;
  endsequence
  sequence apb_done;
    psel_in && penable_in && pready_out;
  endsequence

  setup_ready_a: assert property (apb_setup |=> pready_out)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (apb_done and paddr_in >= 8'h1C
    |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  read_width_a: assert property (apb_done |-> prdata_out[31:8] == 24'h0)
    else $error("read data above a byte");
  settings_hold_a: assert property (busy_q && !conv_done_in
    |=> $stable(chan_sel_out) && $stable(ref_src_out))
    else $error("settings moved during conversion");
  len_clear_a: assert property (ce_in && !busy_q && conv_start_in
    && !psel_in |-> ##2 conv_len_out == NORMAL_CONV_CLKS)
    else $error("long length kept after start");
  temp_route_a: assert property (chan_sel_out.temp_sensor_en
    == (chan_sel_out.pos_in == IN_TEMP))
    else $error("sensor enable and routing differ");
  diff_pair_a: assert property (chan_sel_out.differential |->
    (chan_sel_out.pos_in == IN_TWO && chan_sel_out.neg_in inside
     {IN_TWO, IN_THREE}) || (chan_sel_out.pos_in == IN_ZERO &&
     chan_sel_out.neg_in inside {IN_ZERO, IN_ONE}))
    else $error("illegal differential pair");
  single_end_a: assert property (!chan_sel_out.differential
    |-> chan_sel_out.neg_in == IN_NONE && !chan_sel_out.gain_20x)
    else $error("single input with negative side");
  ref_legal_a: assert property (ref_src_out <= REF_INT_2V56_C)
    else $error("undefined reference source");
endmodule

bind adc_mux_ref_result_format adc_mux_ref_result_format_chk chk_i (
  .ref_clk_in, .rst_in, .ce_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
  .conv_start_in, .conv_done_in, .conv_raw_in, .chan_sel_out,
  .ref_src_out, .conv_len_out, .irq_out);

// File: testbench/conv_core_model.sv
// Behavioural converter core answering start requests from the bench
`timescale 1ns/10ps
module conv_core_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        go_in,
  input  wire logic [10:0] raw_val_in,
  input  wire logic [4:0]  conv_len_in,
  output logic             start_out,
  output logic             done_out,
  output logic [10:0]      raw_out
);
  int cnt;

  // Runs for the length the block asks; raw toggles outside done so a
  // result taken at the wrong cycle shows up as junk
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 0;
      start_out <= 1'h0;
      done_out <= 1'h0;
      raw_out <= 11'h555;
    end else begin
      start_out <= go_in && cnt == 0;
      done_out <= cnt == 1;
      raw_out <= (cnt == 1) ? raw_val_in : ~raw_out;
      if (go_in && cnt == 0)
        cnt <= conv_len_in;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule

// File: testbench/tb_adc_mux_ref_result_format.sv
// Self-checking bench of the converter control block
`timescale 1ns/10ps
module tb_adc_mux_ref_result_format;
  import adc_ctrl_pkg::*;
  logic        ref_clk, rst, psel, penable, pwrite, go, pready, pslverr;
  logic        start, done, irq, err, ce;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [10:0] raw_val, raw;
  logic [4:0]  conv_len;
  chan_sel_t   chan_sel;
  ref_src_t    ref_src;
  int          bad_count, cmp_count;
  int          cycles = 0;

  adc_mux_ref_result_format adc_mux_ref_result_format_i (
    .ref_clk_in(ref_clk), .rst_in(rst), .ce_in(ce), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .conv_start_in(start), .conv_done_in(done),
    .conv_raw_in(raw), .chan_sel_out(chan_sel), .ref_src_out(ref_src),
    .conv_len_out(conv_len), .irq_out(irq));
  conv_core_model conv_core_model_i (
    .clk_in(ref_clk), .rst_in(rst), .go_in(go), .raw_val_in(raw_val),
    .conv_len_in(conv_len), .start_out(start), .done_out(done),
    .raw_out(raw));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds the request until ready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    // No wait count of our own; only the hang guard ends a stuck transfer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    chk(q, exp);
  endtask

  function automatic logic [7:0] fmt(input logic [9:0] v, input logic l,
                                     input logic h);
    if (l)
      return h ? v[9:2] : {v[1:0], 6'h00};
    return h ? {6'h00, v[9:8]} : v[7:0];
  endfunction

  // Low byte first, then high, as the pairing demands
  task automatic resc(input logic [9:0] v, input logic l);
    rd(ADDR_RESULT_LOW, 32'(fmt(v, l, 1'h0)));
    rd(ADDR_RESULT_HIGH, 32'(fmt(v, l, 1'h1)));
  endtask

  task automatic kick(input logic [10:0] r);
    @(posedge ref_clk);
    go <= 1'h1;
    raw_val <= r;
    @(posedge ref_clk);
    go <= 1'h0;
  endtask

  task automatic finish_conv();
    int n;
    n = 0;
    while (done !== 1'h1 && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic conv(input logic [10:0] r);
    kick(r);
    finish_conv();
  endtask

  function automatic chan_sel_t exp_chan(input logic [3:0] c);
    chan_sel_t s;
    s = '0;
    s.neg_in = IN_NONE;
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: s.pos_in = analog_in_t'(c[2:0]);
      4'hC: s.pos_in = IN_BANDGAP;
      4'hD: s.pos_in = IN_GROUND;
      4'hE: s.pos_in = IN_NONE;
      4'hF: begin
        s.pos_in = IN_TEMP;
        s.temp_sensor_en = 1'h1;
      end
      default: begin
        s.differential = 1'h1;
        s.gain_20x = c[0];
        s.pos_in = c[3] ? IN_ZERO : IN_TWO;
        case (c[2:1])
          2'h2: s.neg_in = IN_TWO;
          2'h3: s.neg_in = IN_THREE;
          2'h0: s.neg_in = IN_ZERO;
          default: s.neg_in = IN_ONE;
        endcase
      end
    endcase
    return s;
  endfunction

  function automatic ref_src_t exp_ref(input logic [2:0] r);
    case (r)
      3'h2: return REF_INT_1V1;
      3'h3: return REF_RESERVED;
      3'h6: return REF_INT_2V56;
      3'h7: return REF_INT_2V56_C;
      default: return r[0] ? REF_EXT_PIN : REF_SUPPLY;
    endcase
  endfunction

  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    {rst, psel, penable, pwrite, go, ce} = 6'h21;
    {paddr, pwdata, raw_val} = '0;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    rd(ADDR_INPUT_REF, 32'(INPUT_REF_RESET));
    rd(ADDR_CTRL_B, 32'(CTRL_B_RESET));
    chk(32'(conv_len), 32'(NORMAL_CONV_CLKS));
    wr(ADDR_CTRL_B, 32'hFFFFFFFF);
    rd(ADDR_CTRL_B, 32'(CTRL_B_WMASK));
    wr(ADDR_CTRL_B, 32'h0);
    rd(8'h20, 32'h0);
    chk(32'(err), 32'h1);
    $display("test registers done");
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_INPUT_REF, 32'(c));
      repeat (2) @(posedge ref_clk);
      chk(32'(chan_sel), 32'(exp_chan(4'(c))));
    end
    $display("test channels done");
    for (int r = 1; r < 9; r++) begin
      wr(ADDR_INPUT_REF, 32'({r[1:0], 1'h0, r[2], 4'h0}));
      repeat (2) @(posedge ref_clk);
      chk(32'(ref_src), 32'(exp_ref(3'(r))));
      chk(32'(conv_len), 32'(LONG_CONV_CLKS));
    end
    $display("test references done");
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_INPUT_REF, 32'h6);
    conv(11'h7FB);
    chk(32'(conv_len), 32'(NORMAL_CONV_CLKS));
    chk(32'(irq), 32'h1);
    resc(UNI_MIN, 1'h0);
    conv(11'h3FF);
    resc(UNI_MAX, 1'h0);
    wr(ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h0);
    wr(ADDR_IRQ_STATUS, 32'h3);
    rd(ADDR_IRQ_STATUS, 32'h0);
    // Reversed polarity turns a small negative difference positive
    wr(ADDR_CTRL_B, 32'h20);
    conv(11'h7FB);
    resc(10'h005, 1'h0);
    wr(ADDR_CTRL_B, 32'h80);
    conv(11'h400);
    resc(BIP_MIN, 1'h0);
    conv(11'h7FE);
    resc(10'h3FF, 1'h0);
    conv(11'h3FF);
    resc(BIP_MAX, 1'h0);
    wr(ADDR_INPUT_REF, 32'h26);
    resc(BIP_MAX, 1'h1);
    $display("test results done");
    rd(ADDR_RESULT_LOW, 32'(fmt(BIP_MAX, 1'h1, 1'h0)));
    conv(11'h400);
    rd(ADDR_RESULT_HIGH, 32'(fmt(BIP_MAX, 1'h1, 1'h1)));
    xfer(1'h0, ADDR_IRQ_STATUS, 32'h0);
    chk(32'(q[EV_DROPPED_POS]), 32'h1);
    $display("test freeze done");
    wr(ADDR_INPUT_REF, 32'h0);
    kick(11'h100);
    repeat (3) @(posedge ref_clk);
    wr(ADDR_INPUT_REF, 32'h5F);
    // Give an idle design time to follow, so a leak would show
    repeat (2) @(posedge ref_clk);
    chk(32'(chan_sel), 32'(exp_chan(4'h0)));
    chk(32'(ref_src), 32'(REF_SUPPLY));
    finish_conv();
    chk(32'(chan_sel), 32'(exp_chan(4'hF)));
    chk(32'(ref_src), 32'(REF_EXT_PIN));
    chk(32'(conv_len), 32'(LONG_CONV_CLKS));
    $display("test busy change done");
    // A conversion run while frozen must leave no trace
    wr(ADDR_IRQ_STATUS, 32'h3);
    ce <= 1'h0;
    conv(11'h100);
    ce <= 1'h1;
    rd(ADDR_IRQ_STATUS, 32'h0);
    rd(ADDR_CONV_STATE, 32'h0);
    $display("test clock enable done");
    give_verdict();
  end
endmodule
